/* File: include/dtc_pkg.sv */
// shared constants for the dual timer/counter block
package dtc_pkg;
    localparam logic [7:0] ADDR_CTRL  = 8'h88;
    localparam logic [7:0] ADDR_MODE  = 8'h89;
    localparam logic [7:0] ADDR_T0LO  = 8'h8A;
    localparam logic [7:0] ADDR_T1LO  = 8'h8B;
    localparam logic [7:0] ADDR_T0HI  = 8'h8C;
    localparam logic [7:0] ADDR_T1HI  = 8'h8D;
    localparam logic [7:0] ADDR_AUX   = 8'h8E;
    localparam logic [7:0] ADDR_WAKE  = 8'h8F;
    localparam logic [7:0] REG_RESET  = 8'h00;
    // control register bits
    localparam int CTRL_TF1 = 7;
    localparam int CTRL_TR1 = 6;
    localparam int CTRL_TF0 = 5;
    localparam int CTRL_TR0 = 4;
    localparam int CTRL_IE1 = 3;
    localparam int CTRL_IT1 = 2;
    localparam int CTRL_IE0 = 1;
    localparam int CTRL_IT0 = 0;
    // mode group fields, offset within each 4-bit group
    localparam int MODE_GRP_W = 4;
    localparam int MODE_QUAL  = 3;
    localparam int MODE_FUNC  = 2;
    localparam int MODE_HI    = 1;
    localparam int MODE_LO    = 0;
    // auxiliary register fast clock selects
    localparam int AUX_T0_FAST = 7;
    localparam int AUX_T1_FAST = 6;
    // operating modes
    localparam logic [1:0] MODE_13BIT  = 2'h0;
    localparam logic [1:0] MODE_16BIT  = 2'h1;
    localparam logic [1:0] MODE_RELOAD = 2'h2;
    localparam logic [1:0] MODE_SPLIT  = 2'h3;
    localparam int PRESCALE_DIV = 12;
    localparam logic [3:0] PRESCALE_LAST = 4'hB;
    localparam logic [7:0] LOW5_MASK = 8'h1F;
    typedef enum logic [1:0] {ACC_IDLE, ACC_WRITE} dtc_acc_t;
endpackage

/* File: logic/dtc_edge_sync.sv */
// two-stage synchroniser with falling edge detect for one pin
`timescale 1ns/1ps
module dtc_edge_sync
    import dtc_pkg::*;
(
    // clock and reset
    input  wire logic clk,
    input  wire logic rst_n,
    // pin in
    input  wire logic pin,
    // synchronised level and edge
    output logic      level,
    output logic      fall
);
    logic meta_reg;
    logic sync_reg;
    logic prev_reg;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_reg <= 1'b1;
            sync_reg <= 1'b1;
            prev_reg <= 1'b1;
        end else begin
            meta_reg <= pin;
            sync_reg <= meta_reg;
            prev_reg <= sync_reg;
        end
    end

    assign level = sync_reg;
    // high sample then low sample
    assign fall  = prev_reg & ~sync_reg;
endmodule

/* File: logic/dtc_timer.sv */
// two timer/counters with shared control and mode registers and separate count registers
`timescale 1ns/1ps
module dtc_timer
    import dtc_pkg::*;
(
    // clock and reset
    input  wire logic       CLK_SYS,
    input  wire logic       RESET_N,
    // register port
    input  wire logic [7:0] ADDR,
    input  wire logic [7:0] WDATA,
    input  wire logic       WR,
    input  wire logic       RD,
    output logic      [7:0] RDATA,
    // interrupt acknowledge pulses from the processor
    input  wire logic       T0_ACK,
    input  wire logic       T1_ACK,
    input  wire logic       IRQ0_ACK,
    input  wire logic       IRQ1_ACK,
    // pins
    input  wire logic       T0_COUNT_PIN,
    input  wire logic       T1_COUNT_PIN,
    input  wire logic       EXT_IRQ0_PIN,
    input  wire logic       EXT_IRQ1_PIN,
    // flags out
    output logic            T0_OVERFLOW_FLAG,
    output logic            T1_OVERFLOW_FLAG,
    output logic            EXT_IRQ0_FLAG,
    output logic            EXT_IRQ1_FLAG
);
    logic       rst_meta_reg;
    logic       rst_sync_reg;
    logic [7:0] ctrl_reg;
    logic [7:0] mode_reg;
    logic [7:0] t0lo_reg;
    logic [7:0] t0hi_reg;
    logic [7:0] t1lo_reg;
    logic [7:0] t1hi_reg;
    logic [7:0] aux_reg;
    logic [7:0] wake_reg;
    logic [3:0] pre_reg [2];
    logic [7:0] rdata_reg;
    logic [7:0] ctrl_next;
    logic [7:0] t0lo_next;
    logic [7:0] t0hi_next;
    logic [7:0] t1lo_next;
    logic [7:0] t1hi_next;
    logic [3:0] pin_fall;
    logic [1:0] pre_tick;
    logic [1:0] tick;
    logic [1:0] enable;
    logic [1:0] mode0;
    logic [1:0] mode1;
    logic [3:0] pin_lvl;
    logic [3:0] pin_in;
    logic [1:0] fast;
    logic [1:0] run;
    logic [1:0] gate_pin;
    logic       inc0;
    logic       inc0_hi;
    logic       inc1;
    logic       ovf0;
    logic       ovf1;
    logic       we_ctrl;
    logic       we_mode;
    logic       we_t0lo;
    logic       we_t0hi;
    logic       we_t1lo;
    logic       we_t1hi;
    logic       we_aux;
    logic       we_wake;
    logic       irq0_set;
    logic       irq1_set;
    logic [8:0] t0lo_sum;
    logic [8:0] t0hi_sum;
    logic [8:0] t1lo_sum;
    logic [8:0] t1hi_sum;
    logic [5:0] t0lo5_sum;
    logic [5:0] t1lo5_sum;
    logic       t0_roll;
    logic       t1_roll;
    logic       t0_carry;
    logic       t1_carry;

    // reset release through two flops
    always_ff @(posedge CLK_SYS or negedge RESET_N) begin
        if (!RESET_N) begin
            rst_meta_reg <= 1'b0;
            rst_sync_reg <= 1'b0;
        end else begin
            rst_meta_reg <= 1'b1;
            rst_sync_reg <= rst_meta_reg;
        end
    end

    // pin synchronisers, count pins then interrupt pins
    assign pin_in = {EXT_IRQ1_PIN, EXT_IRQ0_PIN, T1_COUNT_PIN, T0_COUNT_PIN};
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_sync
            dtc_edge_sync u_sync (
                .clk   (CLK_SYS),
                .rst_n (rst_sync_reg),
                .pin   (pin_in[gi]),
                .level (pin_lvl[gi]),
                .fall  (pin_fall[gi])
            );
        end
    endgenerate

    // address decode
    assign we_ctrl = WR && (ADDR == ADDR_CTRL);
    assign we_mode = WR && (ADDR == ADDR_MODE);
    assign we_t0lo = WR && (ADDR == ADDR_T0LO);
    assign we_t1lo = WR && (ADDR == ADDR_T1LO);
    assign we_t0hi = WR && (ADDR == ADDR_T0HI);
    assign we_t1hi = WR && (ADDR == ADDR_T1HI);
    assign we_aux  = WR && (ADDR == ADDR_AUX);
    assign we_wake = WR && (ADDR == ADDR_WAKE);

    // per-timer controls
    assign mode0    = mode_reg[MODE_HI:MODE_LO];
    assign mode1    = mode_reg[MODE_GRP_W + MODE_HI:MODE_GRP_W + MODE_LO];
    assign fast     = {aux_reg[AUX_T1_FAST], aux_reg[AUX_T0_FAST]};
    assign run      = {ctrl_reg[CTRL_TR1], ctrl_reg[CTRL_TR0]};
    assign gate_pin = pin_lvl[3:2];

    // prescaler and tick source per timer
    generate
        for (gi = 0; gi < 2; gi++) begin : g_tick
            // divide by 12 unless fast select set
            assign pre_tick[gi] = fast[gi] || (pre_reg[gi] == PRESCALE_LAST);
            // function select: pin falls or prescaler
            assign tick[gi]     = mode_reg[gi * MODE_GRP_W + MODE_FUNC] ? pin_fall[gi] : pre_tick[gi];
            // run bit and gate qualification
            assign enable[gi]   = run[gi] && (!mode_reg[gi * MODE_GRP_W + MODE_QUAL] || gate_pin[gi]);
            always_ff @(posedge CLK_SYS or negedge rst_sync_reg) begin
                if (!rst_sync_reg) begin
                    pre_reg[gi] <= 4'h0;
                end else begin
                    pre_reg[gi] <= (pre_reg[gi] == PRESCALE_LAST) ? 4'h0 : pre_reg[gi] + 4'h1;
                end
            end
        end
    endgenerate

    // increments
    assign inc0    = tick[0] && enable[0];
    assign inc0_hi = pre_tick[1] && run[1];
    assign inc1    = tick[1] && enable[1] && (mode1 != MODE_SPLIT);

    assign t0lo_sum  = {1'b0, t0lo_reg} + 9'h001;
    assign t0hi_sum  = {1'b0, t0hi_reg} + 9'h001;
    assign t1lo_sum  = {1'b0, t1lo_reg} + 9'h001;
    assign t1hi_sum  = {1'b0, t1hi_reg} + 9'h001;
    assign t0lo5_sum = {1'b0, t0lo_reg[4:0]} + 6'h01;
    assign t1lo5_sum = {1'b0, t1lo_reg[4:0]} + 6'h01;
    assign t0_carry  = (mode0 == MODE_13BIT) ? t0lo5_sum[5] : t0lo_sum[8];
    assign t1_carry  = (mode1 == MODE_13BIT) ? t1lo5_sum[5] : t1lo_sum[8];

    // timer zero next count, software writes win
    always_comb begin
        t0lo_next = t0lo_reg;
        t0hi_next = t0hi_reg;
        t0_roll   = 1'b0;
        if (inc0) begin
            case (mode0)
                MODE_13BIT: begin
                    t0lo_next = (t0lo_reg & ~LOW5_MASK) | {3'h0, t0lo5_sum[4:0]};
                    if (t0_carry) begin
                        t0hi_next = t0hi_sum[7:0];
                        t0_roll   = t0hi_sum[8];
                    end
                end
                MODE_16BIT: begin
                    t0lo_next = t0lo_sum[7:0];
                    if (t0_carry) begin
                        t0hi_next = t0hi_sum[7:0];
                        t0_roll   = t0hi_sum[8];
                    end
                end
                MODE_RELOAD: begin
                    t0lo_next = t0_carry ? t0hi_reg : t0lo_sum[7:0];
                    t0_roll   = t0_carry;
                end
                default: begin
                    t0lo_next = t0lo_sum[7:0];
                    t0_roll   = t0_carry;
                end
            endcase
        end
        if (mode0 == MODE_SPLIT && inc0_hi) begin
            t0hi_next = t0hi_sum[7:0];
        end
        if (we_t0lo) begin
            t0lo_next = WDATA;
        end
        if (we_t0hi) begin
            t0hi_next = WDATA;
        end
    end

    // timer one next count
    always_comb begin
        t1lo_next = t1lo_reg;
        t1hi_next = t1hi_reg;
        t1_roll   = 1'b0;
        if (inc1) begin
            case (mode1)
                MODE_13BIT: begin
                    t1lo_next = (t1lo_reg & ~LOW5_MASK) | {3'h0, t1lo5_sum[4:0]};
                    if (t1_carry) begin
                        t1hi_next = t1hi_sum[7:0];
                        t1_roll   = t1hi_sum[8];
                    end
                end
                MODE_16BIT: begin
                    t1lo_next = t1lo_sum[7:0];
                    if (t1_carry) begin
                        t1hi_next = t1hi_sum[7:0];
                        t1_roll   = t1hi_sum[8];
                    end
                end
                MODE_RELOAD: begin
                    t1lo_next = t1_carry ? t1hi_reg : t1lo_sum[7:0];
                    t1_roll   = t1_carry;
                end
                default: begin
                    t1lo_next = t1lo_reg;
                end
            endcase
        end
        if (we_t1lo) begin
            t1lo_next = WDATA;
        end
        if (we_t1hi) begin
            t1hi_next = WDATA;
        end
    end

    // overflow sources; split mode high byte drives timer one flag
    assign ovf0     = t0_roll;
    assign ovf1     = t1_roll || (mode0 == MODE_SPLIT && inc0_hi && t0hi_sum[8]);
    // level or falling edge trigger
    assign irq0_set = ctrl_reg[CTRL_IT0] ? pin_fall[2] : !pin_lvl[2];
    assign irq1_set = ctrl_reg[CTRL_IT1] ? pin_fall[3] : !pin_lvl[3];

    // control register next, set beats clear
    always_comb begin
        ctrl_next           = we_ctrl ? WDATA : ctrl_reg;
        ctrl_next[CTRL_TF0] = (ctrl_next[CTRL_TF0] && !T0_ACK) || ovf0;
        ctrl_next[CTRL_TF1] = (ctrl_next[CTRL_TF1] && !T1_ACK) || ovf1;
        ctrl_next[CTRL_IE0] = (ctrl_next[CTRL_IE0] && !IRQ0_ACK) || irq0_set;
        ctrl_next[CTRL_IE1] = (ctrl_next[CTRL_IE1] && !IRQ1_ACK) || irq1_set;
    end

    // register file, all zero at reset
    always_ff @(posedge CLK_SYS or negedge rst_sync_reg) begin
        if (!rst_sync_reg) begin
            ctrl_reg <= REG_RESET;
            mode_reg <= REG_RESET;
            t0lo_reg <= REG_RESET;
            t0hi_reg <= REG_RESET;
            t1lo_reg <= REG_RESET;
            t1hi_reg <= REG_RESET;
            aux_reg  <= REG_RESET;
            wake_reg <= REG_RESET;
        end else begin
            ctrl_reg <= ctrl_next;
            mode_reg <= we_mode ? WDATA : mode_reg;
            t0lo_reg <= t0lo_next;
            t0hi_reg <= t0hi_next;
            t1lo_reg <= t1lo_next;
            t1hi_reg <= t1hi_next;
            aux_reg  <= we_aux ? WDATA : aux_reg;
            wake_reg <= we_wake ? WDATA : wake_reg;
        end
    end

    // registered read data
    always_ff @(posedge CLK_SYS or negedge rst_sync_reg) begin
        if (!rst_sync_reg) begin
            rdata_reg <= REG_RESET;
        end else if (RD) begin
            case (ADDR)
                ADDR_CTRL: rdata_reg <= ctrl_reg;
                ADDR_MODE: rdata_reg <= mode_reg;
                ADDR_T0LO: rdata_reg <= t0lo_reg;
                ADDR_T1LO: rdata_reg <= t1lo_reg;
                ADDR_T0HI: rdata_reg <= t0hi_reg;
                ADDR_T1HI: rdata_reg <= t1hi_reg;
                ADDR_AUX:  rdata_reg <= aux_reg;
                ADDR_WAKE: rdata_reg <= wake_reg;
                default:   rdata_reg <= REG_RESET;
            endcase
        end
    end

    assign RDATA            = rdata_reg;
    assign T0_OVERFLOW_FLAG = ctrl_reg[CTRL_TF0];
    assign T1_OVERFLOW_FLAG = ctrl_reg[CTRL_TF1];
    assign EXT_IRQ0_FLAG    = ctrl_reg[CTRL_IE0];
    assign EXT_IRQ1_FLAG    = ctrl_reg[CTRL_IE1];
endmodule

/* File: dv/dtc_timer_asserts.sv */
// port checker for the dual timer/counter
`timescale 1ns/1ps
module dtc_timer_asserts
    import dtc_pkg::*;
(
    // clock and reset
    input wire logic       CLK_SYS,
    input wire logic       RESET_N,
    // register port
    input wire logic [7:0] ADDR,
    input wire logic [7:0] WDATA,
    input wire logic       WR,
    input wire logic       RD,
    input wire logic [7:0] RDATA,
    // acknowledges, pins, flags
    input wire logic       T0_ACK,
    input wire logic       IRQ0_ACK,
    input wire logic       IRQ1_ACK,
    input wire logic       EXT_IRQ0_PIN,
    input wire logic       EXT_IRQ1_PIN,
    input wire logic       T0_OVERFLOW_FLAG,
    input wire logic       T1_OVERFLOW_FLAG,
    input wire logic       EXT_IRQ0_FLAG,
    input wire logic       EXT_IRQ1_FLAG
);
    wire ctrl_wr = (WR && (ADDR == ADDR_CTRL));
    default clocking cb @(posedge CLK_SYS);
    endclocking
    default disable iff (!RESET_N);
    sequence irq0_low_s;
        $fell(EXT_IRQ0_PIN) ##1 (!EXT_IRQ0_PIN && !IRQ0_ACK && !ctrl_wr) [*5];
    endsequence
    sequence irq1_low_s;
        $fell(EXT_IRQ1_PIN) ##1 (!EXT_IRQ1_PIN && !IRQ1_ACK && !ctrl_wr) [*5];
    endsequence
    irq0_flag_set_a: assert property (irq0_low_s |-> EXT_IRQ0_FLAG)
        else $error("irq0 flag not set");
    irq1_flag_set_a: assert property (irq1_low_s |-> EXT_IRQ1_FLAG)
        else $error("irq1 flag not set");
    unmapped_read_a: assert property (RD && ADDR[7:3] != 5'h11 |=> RDATA == 8'h00)
        else $error("unmapped read not zero");
    ctrl_layout_a: assert property (RD && ADDR == ADDR_CTRL |=>
        RDATA[7] == $past(T1_OVERFLOW_FLAG) && RDATA[5] == $past(T0_OVERFLOW_FLAG)
        && RDATA[3] == $past(EXT_IRQ1_FLAG) && RDATA[1] == $past(EXT_IRQ0_FLAG))
        else $error("control bits misplaced");
    tf0_write_a: assert property (ctrl_wr && WDATA[CTRL_TF0] && !T0_ACK |=> T0_OVERFLOW_FLAG)
        else $error("tf0 write lost");
    ie1_write_a: assert property (ctrl_wr && WDATA[CTRL_IE1] && !IRQ1_ACK |=> EXT_IRQ1_FLAG)
        else $error("ie1 write lost");
    tf0_clear_a: assert property ($fell(T0_OVERFLOW_FLAG) |-> $past(T0_ACK) || $past(ctrl_wr))
        else $error("tf0 cleared without cause");
    ie0_clear_a: assert property ($fell(EXT_IRQ0_FLAG) |-> $past(IRQ0_ACK) || $past(ctrl_wr))
        else $error("ie0 cleared without cause");
    rdata_hold_a: assert property (!RD |=> $stable(RDATA))
        else $error("read data changed without read");
endmodule

bind dtc_timer dtc_timer_asserts u_chk (
    .CLK_SYS, .RESET_N, .ADDR, .WDATA, .WR, .RD, .RDATA, .T0_ACK, .IRQ0_ACK, .IRQ1_ACK,
    .EXT_IRQ0_PIN, .EXT_IRQ1_PIN, .T0_OVERFLOW_FLAG, .T1_OVERFLOW_FLAG, .EXT_IRQ0_FLAG, .EXT_IRQ1_FLAG
);

/* File: dv/dtc_pin_model.sv */
// far-side model of the count and interrupt pins
`timescale 1ns/1ps
module dtc_pin_model (
    // clock
    input  wire logic clk,
    // pins
    output logic      t0_pin,
    output logic      t1_pin,
    output logic      irq0_pin,
    output logic      irq1_pin
);
    initial begin
        t0_pin = 1'b1;
        t1_pin = 1'b1;
        irq0_pin = 1'b1;
        irq1_pin = 1'b1;
    end
    // falls on both count pins, each level held 12 clocks
    task automatic burst(input int n0, input int n1);
        for (int i = 0; i < n0 || i < n1; i++) begin
            repeat (12) @(negedge clk);
            t0_pin = (i >= n0);
            t1_pin = (i >= n1);
            repeat (12) @(negedge clk);
            t0_pin = 1'b1;
            t1_pin = 1'b1;
        end
    endtask
    // interrupt pin levels, then settle
    task automatic irq(input logic l0, input logic l1);
        @(negedge clk);
        irq0_pin = l0;
        irq1_pin = l1;
        repeat (6) @(negedge clk);
    endtask
endmodule

/* File: dv/tb_dtc_timer.sv */
// self-checking bench for the dual timer/counter
`timescale 1ns/1ps
module tb_dtc_timer;
    import dtc_pkg::*;
    logic        clk_sys     = 1'b0;
    logic        reset_n     = 1'b0;
    logic [7:0]  addr        = 8'h00;
    logic [7:0]  wdata       = 8'h00;
    logic        wr          = 1'b0;
    logic        rd          = 1'b0;
    logic        t0_ack      = 1'b0;
    logic        irq0_ack    = 1'b0;
    logic        t1_ack      = 1'b0;
    logic        irq1_ack    = 1'b0;
    logic        rd_q        = 1'b0;
    logic        ok;
    logic [7:0]  rdata;
    logic        t0p, t1p, i0p, i1p, tf0, tf1, ie0, ie1;
    logic [7:0]  rbit, fbit;
    logic [15:0] exp_q[$];
    logic [15:0] e;
    logic [31:0] rng         = 32'h11;
    logic [7:0]  base[3]     = '{8'hE0, 8'h00, 8'hF0};
    int          error_cnt   = 0;
    int          comparisons = 0;
    int          cycles      = 0;

    always #5 clk_sys = ~clk_sys;

    dtc_timer DUT (
        .CLK_SYS(clk_sys), .RESET_N(reset_n), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata),
        .T0_ACK(t0_ack), .T1_ACK(t1_ack), .IRQ0_ACK(irq0_ack), .IRQ1_ACK(irq1_ack),
        .T0_COUNT_PIN(t0p), .T1_COUNT_PIN(t1p), .EXT_IRQ0_PIN(i0p), .EXT_IRQ1_PIN(i1p),
        .T0_OVERFLOW_FLAG(tf0), .T1_OVERFLOW_FLAG(tf1), .EXT_IRQ0_FLAG(ie0), .EXT_IRQ1_FLAG(ie1)
    );
    dtc_pin_model pm (.clk(clk_sys), .t0_pin(t0p), .t1_pin(t1p), .irq0_pin(i0p), .irq1_pin(i1p));

    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk_sys);
        addr = a;
        wdata = d;
        wr = 1'b1;
        @(negedge clk_sys);
        wr = 1'b0;
    endtask
    // read, noting the accepted range
    task automatic rd_reg(input logic [7:0] a, input logic [7:0] lo, input logic [7:0] hi);
        @(negedge clk_sys);
        addr = a;
        rd = 1'b1;
        exp_q.push_back({lo, hi});
        @(negedge clk_sys);
        rd = 1'b0;
    endtask
    task automatic clear_all();
        for (logic [7:0] a = ADDR_CTRL; a <= ADDR_WAKE; a++)
            wr_reg(a, 8'h00);
    endtask
    // start, wait, check control mid-run, stop
    task automatic run(input logic [7:0] c, input int n, input logic [7:0] x);
        wr_reg(ADDR_CTRL, c);
        repeat (n) @(negedge clk_sys);
        rd_reg(ADDR_CTRL, x, x);
        wr_reg(ADDR_CTRL, 8'h00);
    endtask
    task automatic final_report();
        $display("comparisons %0d, mismatches %0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    always @(posedge clk_sys) rd_q <= rd;
    always @(negedge clk_sys) begin
        cycles = cycles + 1;
        if (rd_q) begin
            e = exp_q.pop_front();
            ok = (rdata >= e[15:8]) && (rdata <= e[7:0]);
            comparisons = comparisons + 1;
            if (ok !== 1'b1) begin
                error_cnt = error_cnt + 1;
                $display("wrong value at %0t: got %h, want %h..%h", $time, rdata, e[15:8], e[7:0]);
            end
        end
        if (cycles == 8000) begin
            error_cnt = error_cnt + 1;
            final_report();
        end
    end

    initial begin
        repeat (2) @(negedge clk_sys);
        reset_n = 1'b1;
        repeat (3) @(negedge clk_sys);
        for (logic [8:0] a = 9'h087; a <= 9'h090; a++)
            rd_reg(a[7:0], 8'h00, 8'h00);
        for (logic [7:0] a = ADDR_MODE; a <= ADDR_WAKE; a++) begin
            rng = xs(rng);
            wr_reg(a, rng[7:0]);
            rd_reg(a, rng[7:0], rng[7:0]);
        end
        $display("test registers done");
        for (int t = 0; t < 2; t++) begin
            for (int f = 0; f < 2; f++) begin
                rbit = (t == 1) ? 8'h40 : 8'h10;
                fbit = (t == 1) ? 8'h40 : 8'h80;
                clear_all();
                wr_reg(ADDR_MODE, 8'h11);
                wr_reg(ADDR_AUX, (f == 1) ? fbit : 8'h00);
                run(rbit, 117, rbit);
                rd_reg(ADDR_T0LO + t[7:0], (f == 1) ? 8'h75 : 8'h09, (f == 1) ? 8'h7A : 8'h0B);
                rd_reg(ADDR_T1LO - t[7:0], 8'h00, 8'h00);
            end
        end
        $display("test prescale done");
        clear_all();
        wr_reg(ADDR_MODE, 8'h55);
        wr_reg(ADDR_CTRL, 8'h50);
        pm.burst(5, 3);
        rd_reg(ADDR_T0LO, 8'h05, 8'h05);
        rd_reg(ADDR_T1LO, 8'h03, 8'h03);
        $display("test event count done");
        clear_all();
        wr_reg(ADDR_MODE, 8'h09);
        wr_reg(ADDR_AUX, 8'h80);
        pm.irq(1'b0, 1'b1);
        run(8'h10, 37, 8'h12);
        rd_reg(ADDR_T0LO, 8'h00, 8'h00);
        pm.irq(1'b1, 1'b1);
        run(8'h10, 37, 8'h10);
        rd_reg(ADDR_T0LO, 8'h25, 8'h2A);
        $display("test gate done");
        for (int t = 0; t < 2; t++) begin
            for (int i = 0; i < 3; i++) begin
                rbit = (t == 1) ? 8'h40 : 8'h10;
                fbit = (t == 1) ? 8'h40 : 8'h80;
                clear_all();
                wr_reg(ADDR_MODE, (t == 1) ? {i[3:0], 4'h0} : i[7:0]);
                wr_reg(ADDR_AUX, fbit);
                wr_reg(ADDR_T0HI + t[7:0], (i == 2) ? 8'hF0 : 8'hFF);
                wr_reg(ADDR_T0LO + t[7:0], 8'hFE);
                run(rbit, 7, rbit | ((t == 1) ? 8'h80 : 8'h20));
                rd_reg(ADDR_T0LO + t[7:0], base[i] + 8'h06, base[i] + 8'h09);
                rd_reg(ADDR_T0HI + t[7:0], (i == 2) ? 8'hF0 : 8'h00, (i == 2) ? 8'hF0 : 8'h00);
            end
        end
        clear_all();
        wr_reg(ADDR_MODE, 8'h33);
        wr_reg(ADDR_AUX, 8'hC0);
        run(8'h50, 17, 8'h50);
        rd_reg(ADDR_T0LO, 8'h11, 8'h16);
        rd_reg(ADDR_T0HI, 8'h11, 8'h16);
        rd_reg(ADDR_T1LO, 8'h00, 8'h00);
        $display("test modes done");
        clear_all();
        wr_reg(ADDR_CTRL, 8'hAA);
        rd_reg(ADDR_CTRL, 8'hAA, 8'hAA);
        @(negedge clk_sys);
        t0_ack = 1'b1;
        irq0_ack = 1'b1;
        @(negedge clk_sys);
        t0_ack = 1'b0;
        irq0_ack = 1'b0;
        rd_reg(ADDR_CTRL, 8'h88, 8'h88);
        @(negedge clk_sys);
        t1_ack = 1'b1;
        irq1_ack = 1'b1;
        @(negedge clk_sys);
        t1_ack = 1'b0;
        irq1_ack = 1'b0;
        rd_reg(ADDR_CTRL, 8'h00, 8'h00);
        wr_reg(ADDR_CTRL, 8'h05);
        pm.irq(1'b0, 1'b0);
        rd_reg(ADDR_CTRL, 8'h0F, 8'h0F);
        comparisons = comparisons + 1;
        if ({tf1, tf0, ie1, ie0} !== 4'h3) begin
            error_cnt = error_cnt + 1;
            $display("wrong value at %0t: flag pins %b", $time, {tf1, tf0, ie1, ie0});
        end
        wr_reg(ADDR_CTRL, 8'h05);
        rd_reg(ADDR_CTRL, 8'h05, 8'h05);
        pm.irq(1'b1, 1'b1);
        $display("test flags done");
        repeat (3) @(negedge clk_sys);
        final_report();
    end
endmodule
